// ---- logic/modem_status_report_framer.sv ----
`timescale 1ns/10ps
`default_nettype none


module modem_status_report_framer
   import status_framer_pkg::*;
#(
   parameter int MAX_ITEMS = 34    // sub-tlvs per status tlv
)
(
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic                         ce,
   input  wire logic                         mac_init,
   input  wire logic                         req_valid,
   output logic                              req_ready,
   input  wire logic [7:0]                   req_event,
   input  wire status_framer_pkg::item_kind_e req_kind,
   input  wire logic [7:0]                   req_count,
   input  wire logic [6:0]                   req_desc_len,
   input  wire logic                         item_valid,
   output logic                              item_ready,
   input  wire logic [47:0]                  item_value,
   input  wire logic                         desc_valid,
   output logic                              desc_ready,
   input  wire logic [7:0]                   desc_byte,
   output logic                              out_valid,
   input  wire logic                         out_ready,
   output logic [7:0]                        out_data,
   output logic                              out_last,
   input  wire logic                         rx_valid,
   input  wire logic [7:0]                   rx_data,
   input  wire logic                         rx_first,
   input  wire logic                         rx_last,
   output logic [15:0]                       ctrl_tid,
   output logic                              ctrl_tid_stb,
   output logic [7:0]                        ctrl_type,
   output logic [7:0]                        ctrl_data,
   output logic                              ctrl_data_stb,
   output logic                              ctrl_end_stb
);

   import status_framer_pkg::*;

   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   // a parent length must fit one byte with full text and dsids
   localparam int WORST_LEN = 2 + 80 + MAX_ITEMS * (2 + 3);
   if (MAX_ITEMS < 1 || WORST_LEN > 255)
      $error("MAX_ITEMS out of range for one-byte tlv length");

   // ***************************************************************
   // framer state
   // ***************************************************************
   typedef enum logic [3:0]
   {
      S_IDLE, S_TID_HI, S_TID_LO, S_EVT, S_TLV_T, S_TLV_L,
      S_DESC_T, S_DESC_L, S_DESC_GET, S_DESC_B,
      S_ITEM_GET, S_SUB_T, S_SUB_L, S_SUB_V
   } fstate_e;

   typedef struct packed
   {
      fstate_e     st;         // frame position
      logic        rdy;        // request ready
      logic        iready;     // item ready
      logic        dready;     // text ready
      logic        ovalid;     // output byte valid
      logic [7:0]  odata;      // output byte
      logic        olast;      // output last flag
      item_kind_e  kind;       // sub-tlv kind
      logic [7:0]  evt;        // event type code
      logic [15:0] tid;        // tid of this report
      logic [6:0]  dlen;       // text length, zero for none
      logic [6:0]  dleft;      // text bytes left
      logic        dnow;       // text goes in this status tlv
      logic [7:0]  cnt;        // items left
      logic [47:0] val;        // item, left aligned
      logic [2:0]  vleft;      // item bytes left
      logic [TID_COUNTERS-1:0][15:0] tids; // last tid per event code
   } fstate_s;

   fstate_s s;        // registered state
   fstate_s next_s;   // next state
   logic    free;     // output slot can take a byte

   // ***************************************************************
   // helpers
   // ***************************************************************
   // wrap past maximum to one
   function automatic logic [15:0] next_tid(input logic [15:0] v);
      return (v == TID_MAX || v == TID_NONE) ? TID_FIRST : v + 16'h0001;
   endfunction : next_tid

   // sub-tlv type code of a kind
   function automatic logic [7:0] sub_type(input item_kind_e k);
      unique case (k)
         KIND_DS_CHAN: return SUB_DS_CHAN;   // downstream id
         KIND_US_CHAN: return SUB_US_CHAN;   // upstream id
         KIND_DSID:    return SUB_DSID;      // dsid code
         KIND_MAC:     return SUB_MAC;       // mac code
         KIND_DS_PROF: return SUB_DS_PROF;   // ofdm code
         KIND_US_PROF: return SUB_US_PROF;   // ofdma code
         default:      return 8'h00;
      endcase
   endfunction : sub_type

   // sub-tlv value length of a kind
   function automatic logic [7:0] sub_len(input item_kind_e k);
      unique case (k)
         KIND_DSID: return LEN_DSID;         // three bytes
         KIND_MAC:  return LEN_MAC;          // six bytes
         KIND_NONE: return 8'h00;
         default:   return LEN_ONE_BYTE;
      endcase
   endfunction : sub_len

   function automatic logic [7:0] parent_len(input item_kind_e k,
                                             input logic [7:0] n,
                                             input logic [6:0] d);
      logic [15:0] sum;
      sum = 16'(n) * 16'(TLV_HDR_LEN + sub_len(k));
      if (d != 7'h00)
         sum = sum + 16'(TLV_HDR_LEN) + 16'(d);
      return sum[7:0];
   endfunction : parent_len

   // ***************************************************************
   // control request side
   // ***************************************************************
   ctrl_req_if creq ();

   assign creq.rx_valid = rx_valid;
   assign creq.rx_data  = rx_data;
   assign creq.rx_first = rx_first;
   assign creq.rx_last  = rx_last;

   ctrl_req_parser u_parser
   (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .bus    (creq.parser)
   );

   // parser outputs are its own flops
   assign ctrl_tid      = creq.tid;
   assign ctrl_tid_stb  = creq.tid_stb;
   assign ctrl_type     = creq.tlv_type;
   assign ctrl_data     = creq.tlv_data;
   assign ctrl_data_stb = creq.data_stb;
   assign ctrl_end_stb  = creq.end_stb;

   // ***************************************************************
   // framer next state
   // ***************************************************************
   assign free = !s.ovalid || out_ready;

   always_comb
   begin
      next_s = s;
      // byte taken downstream empties the slot
      if (s.ovalid && out_ready)
         next_s.ovalid = 1'b0;
      if (mac_init)
         next_s.tids = '0;
      unique case (s.st)
         // waiting for a report request
         S_IDLE:
         begin
            if (req_valid && s.rdy)
            begin
               next_s.rdy   = 1'b0;
               next_s.kind  = req_kind;
               next_s.evt   = req_event;
               next_s.dlen  = (req_desc_len > DESC_MAX) ? DESC_MAX
                                                        : req_desc_len;
               next_s.dnow  = 1'b1;
               // without a kind there is nothing to list
               next_s.cnt   = (req_kind == KIND_NONE) ? 8'h00
                            : (req_kind == KIND_MAC) ? req_count
                            : (req_count > 8'(MAX_ITEMS)) ? 8'(MAX_ITEMS)
                            : req_count;
               next_s.tid   = next_tid(mac_init ? TID_NONE
                                                : s.tids[req_event]);
               next_s.tids[req_event] = next_s.tid;
               next_s.st    = S_TID_HI;
            end
         end
         S_TID_HI:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = s.tid[15:8];
               next_s.olast  = 1'b0;
               next_s.st     = S_TID_LO;
            end
         end
         S_TID_LO:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = s.tid[7:0];
               next_s.st     = S_EVT;
            end
         end
         S_EVT:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = s.evt;
               next_s.st     = S_TLV_T;
            end
         end
         S_TLV_T:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = TLV_STATUS;
               next_s.st     = S_TLV_L;
            end
         end
         S_TLV_L:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = parent_len(s.kind,
                  (s.kind == KIND_MAC && s.cnt != 8'h00) ? 8'h01 : s.cnt,
                  s.dnow ? s.dlen : 7'h00);
               next_s.olast  = !(s.dnow && s.dlen != 7'h00)
                               && s.cnt == 8'h00;
               if (s.dnow && s.dlen != 7'h00)
                  next_s.st = S_DESC_T;
               else if (s.cnt != 8'h00)
               begin
                  next_s.iready = 1'b1;
                  next_s.st     = S_ITEM_GET;
               end
               else
               begin
                  next_s.rdy = 1'b1;
                  next_s.st  = S_IDLE;
               end
            end
         end
         S_DESC_T:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = SUB_DESC;
               next_s.st     = S_DESC_L;
            end
         end
         S_DESC_L:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = {1'b0, s.dlen};
               next_s.dleft  = s.dlen;
               next_s.dnow   = 1'b0;
               next_s.dready = 1'b1;
               next_s.st     = S_DESC_GET;
            end
         end
         // one text byte is held at a time; costs a cycle per byte
         S_DESC_GET:
         begin
            if (desc_valid && s.dready)
            begin
               next_s.dready = 1'b0;
               next_s.val    = {desc_byte, 40'h0};
               next_s.dleft  = s.dleft - 7'h01;
               next_s.st     = S_DESC_B;
            end
         end
         S_DESC_B:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = s.val[47:40];
               next_s.olast  = s.dleft == 7'h00 && s.cnt == 8'h00;
               if (s.dleft != 7'h00)
               begin
                  next_s.dready = 1'b1;
                  next_s.st     = S_DESC_GET;
               end
               else if (s.cnt != 8'h00)
               begin
                  next_s.iready = 1'b1;
                  next_s.st     = S_ITEM_GET;
               end
               else
               begin
                  next_s.rdy = 1'b1;
                  next_s.st  = S_IDLE;
               end
            end
         end
         // items come right aligned; shift so the top byte leads
         S_ITEM_GET:
         begin
            if (item_valid && s.iready)
            begin
               next_s.iready = 1'b0;
               next_s.val    = item_value << (8 * (ITEM_BYTES
                               - int'(sub_len(s.kind))));
               next_s.vleft  = 3'(sub_len(s.kind));
               next_s.cnt    = s.cnt - 8'h01;
               next_s.st     = S_SUB_T;
            end
         end
         S_SUB_T:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = sub_type(s.kind);
               next_s.st     = S_SUB_L;
            end
         end
         S_SUB_L:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = sub_len(s.kind);
               next_s.st     = S_SUB_V;
            end
         end
         // value bytes, most significant first
         S_SUB_V:
         begin
            if (free)
            begin
               next_s.ovalid = 1'b1;
               next_s.odata  = s.val[47:40];
               next_s.val    = {s.val[39:0], 8'h00};
               next_s.vleft  = s.vleft - 3'h1;
               next_s.olast  = s.vleft == 3'h1 && s.cnt == 8'h00;
               if (s.vleft == 3'h1)
               begin
                  if (s.cnt == 8'h00)
                  begin
                     next_s.rdy = 1'b1;
                     next_s.st  = S_IDLE;
                  end
                  else if (s.kind == KIND_MAC)
                     next_s.st = S_TLV_T;
                  else
                  begin
                     next_s.iready = 1'b1;
                     next_s.st     = S_ITEM_GET;
                  end
               end
            end
         end
      endcase
      // clock enable low freezes everything
      if (!ce)
         next_s = s;
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s <= '{st: S_IDLE, rdy: 1'b1, kind: KIND_NONE, default: '0};
      else
         s <= next_s;
   end

   // all handshake outputs come from the state register
   assign req_ready  = s.rdy;
   assign item_ready = s.iready;
   assign desc_ready = s.dready;
   assign out_valid  = s.ovalid;
   assign out_data   = s.odata;
   assign out_last   = s.olast;

endmodule : modem_status_report_framer

`default_nettype wire

// ---- logic/status_framer_pkg.sv ----
package status_framer_pkg;

   // ***************************************************************
   // transaction identifier
   // ***************************************************************
   localparam logic [15:0] TID_NONE  = 16'h0000;   // never sent
   localparam logic [15:0] TID_FIRST = 16'h0001;   // first after init
   localparam logic [15:0] TID_MAX   = 16'hFFFF;   // wraps to first

   // ***************************************************************
   // status report tlv codes and lengths
   // ***************************************************************
   localparam logic [7:0] TLV_STATUS    = 8'h01;  // status event
   localparam logic [7:0] SUB_DESC      = 8'h02;  // vendor text
   localparam logic [7:0] SUB_DS_CHAN   = 8'h04;  // downstream channel
   localparam logic [7:0] SUB_US_CHAN   = 8'h05;  // upstream channel
   localparam logic [7:0] SUB_DSID      = 8'h06;  // dsid value
   localparam logic [7:0] SUB_MAC       = 8'h07;  // removed mac address
   localparam logic [7:0] SUB_DS_PROF   = 8'h08;  // ofdm profile
   localparam logic [7:0] SUB_US_PROF   = 8'h09;  // ofdma profile
   localparam logic [7:0] LEN_ONE_BYTE  = 8'h01;  // channel, profile
   localparam logic [7:0] LEN_DSID      = 8'h03;  // dsid
   localparam logic [7:0] LEN_MAC       = 8'h06;  // mac address
   localparam logic [7:0] TLV_HDR_LEN   = 8'h02;  // type plus length
   localparam logic [6:0] DESC_MAX      = 7'h50;  // 80 text bytes
   localparam logic [7:0] EVT_MAC_REMOVAL = 8'h0B; // mac removal event
   localparam int         ITEM_BYTES    = 6;      // widest item value
   localparam int         TID_COUNTERS  = 256;    // one per event code

   // ***************************************************************
   // control request tlv types understood by the modem
   // ***************************************************************
   localparam logic [7:0] CTRL_TYPE_MIN = 8'h01;
   localparam logic [7:0] CTRL_TYPE_MAX = 8'h08;

   // which sub-tlv an event carries for each instance that is on
   typedef enum logic [2:0]
   {
      KIND_NONE,
      KIND_DS_CHAN,
      KIND_US_CHAN,
      KIND_DSID,
      KIND_MAC,
      KIND_DS_PROF,
      KIND_US_PROF
   } item_kind_e;

endpackage : status_framer_pkg

// ---- logic/ctrl_req_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// received control request bytes in, parsed fields out
interface ctrl_req_if;
   logic       rx_valid;    // byte strobe
   logic [7:0] rx_data;     // message body byte
   logic       rx_first;    // first body byte
   logic       rx_last;     // last body byte
   logic [15:0] tid;        // headend transaction id
   logic       tid_stb;     // tid complete
   logic [7:0] tlv_type;    // current tlv type, known or not
   logic [7:0] tlv_data;    // value byte
   logic       data_stb;    // value byte strobe
   logic       end_stb;     // message finished

   modport parser
   (
      input  rx_valid, rx_data, rx_first, rx_last,
      output tid, tid_stb, tlv_type, tlv_data, data_stb, end_stb
   );
   modport framer
   (
      output rx_valid, rx_data, rx_first, rx_last,
      input  tid, tid_stb, tlv_type, tlv_data, data_stb, end_stb
   );
endinterface : ctrl_req_if

`default_nettype wire

// ---- logic/ctrl_req_parser.sv ----
`timescale 1ns/10ps
`default_nettype none

module ctrl_req_parser
   import status_framer_pkg::*;
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   ctrl_req_if.parser bus
);

   // ***************************************************************
   // parser state
   // ***************************************************************
   typedef enum logic [2:0] {P_TID_HI, P_TID_LO, P_TYPE, P_LEN, P_VAL}
      pstate_e;

   typedef struct packed
   {
      pstate_e     st;        // position in message
      logic [15:0] tid;       // transaction id
      logic        tid_stb;   // tid pulse
      logic [7:0]  typ;       // current tlv type
      logic [7:0]  left;      // value bytes still to come
      logic [7:0]  data;      // value byte out
      logic        data_stb;  // value pulse
      logic        end_stb;   // end pulse
   } pstate_s;

   pstate_s s;        // registered state
   pstate_s next_s;   // next state

   // true for tlv types the modem acts upon
   function automatic logic known(input logic [7:0] t);
      return (t >= CTRL_TYPE_MIN) && (t <= CTRL_TYPE_MAX);
   endfunction : known

   // ***************************************************************
   // byte walk
   // ***************************************************************
   always_comb
   begin
      next_s          = s;
      next_s.tid_stb  = 1'b0;
      next_s.data_stb = 1'b0;
      next_s.end_stb  = 1'b0;
      if (bus.rx_valid)
      begin
         // a first byte always restarts, so a broken message cannot stick
         if (bus.rx_first)
         begin
            next_s.tid[15:8] = bus.rx_data;
            next_s.st        = P_TID_LO;
         end
         else
         begin
            unique case (s.st)
               P_TID_HI:
               begin
                  next_s.tid[15:8] = bus.rx_data;
                  next_s.st        = P_TID_LO;
               end
               P_TID_LO:
               begin
                  next_s.tid[7:0] = bus.rx_data;
                  next_s.tid_stb  = 1'b1;
                  next_s.st       = P_TYPE;
               end
               P_TYPE:
               begin
                  next_s.typ = bus.rx_data;
                  next_s.st  = P_LEN;
               end
               P_LEN:
               begin
                  next_s.left = bus.rx_data;
                  next_s.st   = (bus.rx_data == 8'h00) ? P_TYPE : P_VAL;
               end
               P_VAL:
               begin
                  if (known(s.typ))
                  begin
                     next_s.data     = bus.rx_data;
                     next_s.data_stb = 1'b1;
                  end
                  next_s.left = s.left - 8'h01;
                  if (s.left == 8'h01)
                     next_s.st = P_TYPE;
               end
            endcase
         end
         if (bus.rx_last)
         begin
            next_s.end_stb = 1'b1;
            next_s.st      = P_TID_HI;
         end
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s <= '{st: P_TID_HI, default: '0};
      else if (ce)
         s <= next_s;
   end

   // parsed fields straight from flops
   assign bus.tid      = s.tid;
   assign bus.tid_stb  = s.tid_stb;
   assign bus.tlv_type = s.typ;
   assign bus.tlv_data = s.data;
   assign bus.data_stb = s.data_stb;
   assign bus.end_stb  = s.end_stb;

endmodule : ctrl_req_parser

`default_nettype wire

// ---- testbench/framer_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module framer_sva #(parameter int MAX_ITEMS = 34) (
input wire logic clk, arst_n, ce, req_valid, req_ready, out_valid,
input wire logic out_ready, out_last, rx_valid, rx_first, rx_last,
input wire logic ctrl_tid_stb, ctrl_end_stb,
input wire logic [7:0] req_event, out_data, rx_data,
input wire logic [15:0] ctrl_tid);
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
logic [8:0] idx;
logic [7:0] hi, evt;
// body byte position, held tid byte and taken event code
always_ff @(posedge clk or negedge arst_n)
if (!arst_n) begin idx <= '0; hi <= '0; evt <= '0; end
else begin
if (req_valid && req_ready && ce) evt <= req_event;
if (out_valid && out_ready) idx <= out_last ? 9'h000 : idx + 9'h001;
if (out_valid && out_ready && idx == 9'h000) hi <= out_data;
end
sequence tid_in; rx_valid && rx_first ##1 rx_valid && !rx_first; endsequence
// taken and state moves at one edge, tid byte loads the next edge, sampled the edge after
AST_FIRST: assert property (req_valid && req_ready |-> ##2 out_valid)
else $error("report did not start");
AST_TID_NZ: assert property (out_valid && idx == 9'h001 |->
{hi, out_data} != 16'h0000) else $error("zero tid");
AST_EVT: assert property (out_valid && idx == 9'h002 |-> out_data == evt)
else $error("bad event code");
AST_TLV1: assert property (out_valid && idx == 9'h003 |-> out_data == 8'h01)
else $error("bad status tlv type");
AST_HOLD: assert property (out_valid && !out_ready |=>
out_valid && $stable(out_data)) else $error("byte dropped");
AST_LAST: assert property ($rose(out_valid && out_last) |-> req_ready)
else $error("busy after last byte");
AST_TID_CTRL: assert property (tid_in |=> ctrl_tid_stb &&
ctrl_tid == {$past(rx_data, 2), $past(rx_data)}) else $error("bad tid");
AST_STB1: assert property (ctrl_tid_stb |=> !ctrl_tid_stb)
else $error("tid strobe long");
AST_END: assert property (rx_valid && rx_last |=> ctrl_end_stb)
else $error("no end strobe");
endmodule : framer_sva
bind modem_status_report_framer framer_sva #(.MAX_ITEMS(MAX_ITEMS)) sva_u (.*);
`default_nettype wire

// ---- testbench/headend_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// headend side: takes the report stream, sends control requests
module headend_model (
input wire logic clk, out_valid, out_last,
input wire logic [7:0] out_data,
output logic out_ready, rx_valid, rx_first, rx_last,
output logic [7:0] rx_data);
logic [7:0] got[$];
logic [1:0] s = 2'h0;
logic lst = 0;
int nl = 0;
initial {out_ready, rx_valid, rx_first, rx_last, rx_data} = '0;
// stall one cycle in four
always @(negedge clk) begin s <= s + 2'h1; out_ready <= s != 2'h3; end
// bytes taken, last flag of the newest one and count of flagged bytes
always @(posedge clk) if (out_valid && out_ready) begin
got.push_back(out_data);
lst <= out_last;
nl <= nl + out_last;
end
task automatic send(input logic [7:0] b[$]);
foreach (b[i]) begin
@(negedge clk);
{rx_valid, rx_first, rx_last, rx_data} = {1'b1, i == 0, i == b.size() - 1, b[i]};
end
@(negedge clk);
{rx_valid, rx_last, rx_data} = {2'b00, ~rx_data};
endtask : send
endmodule : headend_model
`default_nettype wire

// ---- testbench/modem_status_report_framer_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
$display("wrong value at %0t: %h not %h", $time, a, b); end end
module modem_status_report_framer_bench;
import status_framer_pkg::*;
logic clk = 0, arst_n = 0, mac_init = 0, req_valid = 0;
logic req_ready, item_ready, desc_ready, out_valid, out_ready, out_last;
logic rx_valid, rx_first, rx_last, ctrl_tid_stb, ctrl_data_stb, ctrl_end_stb;
logic [7:0] req_event = 0, req_count = 0, desc_byte = 0, out_data, rx_data;
logic [7:0] ctrl_type, ctrl_data;
logic [6:0] req_desc_len = 0;
logic [47:0] item_value = 0;
logic [15:0] ctrl_tid;
logic [31:0] rs = 32'h00013B57;
logic [7:0] q[$];
item_kind_e req_kind = KIND_NONE;
int err_count = 0, checks_done = 0, cyc = 0, ii = 0, di = 0, nd = 0, tid[256];
modem_status_report_framer dut_u (.clk, .arst_n, .ce(1'b1), .mac_init,
.req_valid, .req_ready, .req_event, .req_kind, .req_count, .req_desc_len,
.item_valid(1'b1), .item_ready, .item_value, .desc_valid(1'b1), .desc_ready,
.desc_byte, .out_valid, .out_ready, .out_data, .out_last, .rx_valid,
.rx_data, .rx_first, .rx_last, .ctrl_tid, .ctrl_tid_stb, .ctrl_type,
.ctrl_data, .ctrl_data_stb, .ctrl_end_stb);
headend_model hm_u (.clk, .out_valid, .out_last, .out_data, .out_ready,
.rx_valid, .rx_first, .rx_last, .rx_data);
initial forever #50 clk = ~clk;
function automatic logic [31:0] nx(input logic [31:0] s);
return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction : nx
function automatic logic [47:0] iv(input int i);
return {3{16'(i * 16'h3A7D + 16'h1234)}};
endfunction : iv
// items and text bytes advance once taken
always @(posedge clk) begin
ii <= ii + item_ready; di <= di + desc_ready; nd <= nd + ctrl_data_stb;
cyc <= cyc + 1;
end
always @(negedge clk) begin item_value <= iv(ii); desc_byte <= 8'(di * 3 + 1); end
always @(posedge clk) if (cyc == 60000) begin err_count++; finish_test; end
task automatic report(input logic [7:0] e, input item_kind_e k, input int c, d);
int v, per, ng;
v = k == KIND_DSID ? 3 : k == KIND_MAC ? 6 : 1;
per = k == KIND_NONE ? 0 : k == KIND_MAC ? 1 : c;
ng = k == KIND_MAC ? c : 1;
tid[e] = tid[e] == 65535 ? 1 : tid[e] + 1;
q = {8'(tid[e] >> 8), 8'(tid[e]), e};
for (int g = 0; g < ng; g++) begin
q.push_back(8'h01);
q.push_back(8'(per * (2 + v) + (g == 0 && d > 0 ? 2 + d : 0)));
if (g == 0 && d > 0) begin
q.push_back(8'h02); q.push_back(8'(d));
for (int j = 0; j < d; j++) q.push_back(8'((di + j) * 3 + 1));
end
for (int i = 0; i < per; i++) begin
q.push_back(8'(k) + 8'h03); q.push_back(8'(v));
for (int b = v - 1; b >= 0; b--) q.push_back(8'(iv(ii + g + i) >> (8 * b)));
end
end
@(negedge clk);
req_valid = 1;
req_event = e;
req_kind = k;
{req_count, req_desc_len} = {8'(c), 7'(d)};
hm_u.got = {};
hm_u.nl = 0;
do @(posedge clk); while (!req_ready);
@(negedge clk); req_valid = 0;
for (int t = 0; t < 3000 && hm_u.got.size() < q.size(); t++) @(negedge clk);
`CHK(hm_u.got.size(), q.size())
foreach (q[i]) `CHK(hm_u.got[i], q[i])
`CHK(hm_u.nl, 1)
`CHK(hm_u.lst, 1'b1)
endtask : report
task finish_test;
if (err_count == 0 && checks_done > 0) $display("Testbench passed");
else $display("Testbench failed");
$finish;
endtask : finish_test
initial begin
foreach (tid[i]) tid[i] = 0;
repeat (3) @(negedge clk); arst_n = 1;
for (int k = 0; k < 7; k++) report(8'h10 + 8'(k), item_kind_e'(k), 2, k);
report(8'h10, KIND_DS_CHAN, 1, 0);
report(EVT_MAC_REMOVAL, KIND_MAC, 3, 4);
report(8'h07, KIND_DSID, 34, 0);
report(8'h09, KIND_NONE, 0, 80);
for (int n = 0; n < 40; n++) begin
rs = nx(rs);
report(rs[7:0], item_kind_e'(rs[10:8] % 7), 1 + rs[13:11], rs[20:14] % 81);
end
@(negedge clk); mac_init = 1; @(negedge clk); mac_init = 0;
foreach (tid[i]) tid[i] = 0;
report(8'h10, KIND_NONE, 0, 0);
hm_u.send('{8'hAB, 8'hCD, 8'h03, 8'h01, 8'h01, 8'h0C, 8'h01, 8'h77});
repeat (2) @(negedge clk);
`CHK(ctrl_tid, 16'hABCD)
`CHK(nd, 1)
`CHK(ctrl_type, 8'h0C)
`CHK(ctrl_data, 8'h01)
finish_test;
end
endmodule : modem_status_report_framer_bench
`default_nettype wire
